// ### src/nvsc_host.sv
// Summary of operation
// - Six sequence reads, consecutive, exact order
// - Write strobe high through all six
// - Sequence starts 4E38, B1C7, 83E0
// - Fourth and fifth reads 7C1F, 703F
// - Each step is chip-select delimited read
// - Autosave change persists only after save
// - Boot firmware rewrites autosave setting
//
// Purpose: host controller driving the nonvolatile SRAM pins
// Assumes: AXI4-Lite slave, 16-bit data bus, busy pin open drain
// Notes: one operation at a time; status reports completion
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module nvsc_host
	import nvsc_pkg::*;
#(
	parameter int AW = 20
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [3:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// AXI4-Lite read
	input wire logic [3:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Memory pins
	output logic chip_sel_n,
	output logic write_n,
	output logic output_en_n,
	output logic upper_byte_lane_n,
	output logic lower_byte_lane_n,
	output logic [AW-1:0] mem_addr,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic dq_oe_n,
	input wire logic save_busy_n,
	input wire logic low_voltage_threshold
);
	nvsc_state_t state_q;
	logic [2:0] op_q;
	logic [2:0] step_q;
	logic [3:0] cnt_q;
	logic [15:0] addr_q, wdat_q, rdat_q;
	logic done_q, as_en_q, go;
	logic busy_s, lowv_s;
	logic aw_q, w_q;
	logic [3:0] awa_q;
	logic [31:0] wd_q;
	logic [3:0] wst_q;
	logic [15:0] dq_s;

	nvsc_sync #(.W(2)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din({~save_busy_n, low_voltage_threshold}),
		.dout({busy_s, lowv_s})
	);

	// Costs two of the settled cycles before the sample point
	nvsc_sync #(.W(16)) u_dq_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din(dq_in),
		.dout(dq_s)
	);

	function automatic logic [15:0] seq_addr(input logic [2:0] s,
		input logic [2:0] op);
		case (s)
			3'h0: seq_addr = SEQ_A1;
			3'h1: seq_addr = SEQ_A2;
			3'h2: seq_addr = SEQ_A3;
			3'h3: seq_addr = SEQ_A4;
			3'h4: seq_addr = SEQ_A5;
			default: begin
				case (op)
					OP_AS_DIS: seq_addr = SEQ_AS_DIS;
					OP_AS_EN: seq_addr = SEQ_AS_EN;
					OP_SAVE: seq_addr = SEQ_SAVE;
					default: seq_addr = SEQ_RESTORE;
				endcase
			end
		endcase
	endfunction

	wire is_seq = (op_q != OP_READ) && (op_q != OP_WRITE);
	wire last_step = !is_seq || (step_q == 3'h5);
	wire save_like = (op_q == OP_SAVE) || (op_q == OP_RESTORE);

	// AXI write channel capture, either order
	// Readies reopen only once the response is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= 4'h0;
			wd_q <= 32'h0;
			wst_q <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp <= 2'b00;
			s_awready <= 1'b1;
			s_wready <= 1'b1;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_q <= 1'b1;
				awa_q <= s_awaddr;
				s_awready <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_q <= 1'b1;
				wd_q <= s_wdata;
				wst_q <= s_wstrb;
				s_wready <= 1'b0;
			end
			if (aw_q && w_q && !s_bvalid) begin
				s_bvalid <= 1'b1;
				aw_q <= 1'b0;
				w_q <= 1'b0;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
				s_awready <= 1'b1;
				s_wready <= 1'b1;
			end
		end
	end

	// Go strobe: CTRL write of op 0..5 while idle; else ignored
	assign go = aw_q && w_q && !s_bvalid && (awa_q == REG_CTRL)
		&& (state_q == ST_IDLE) && wd_q[0 +: 4] != 4'hF
		&& wd_q[CTRL_OP_LSB +: 3] <= OP_RESTORE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_q <= ADDR_RESET;
			wdat_q <= DATA_RESET;
		end else if (aw_q && w_q && !s_bvalid && state_q == ST_IDLE) begin
			if (awa_q == REG_ADDR && wst_q != 4'h0)
				addr_q <= wd_q[15:0];
			if (awa_q == REG_DATA && wst_q != 4'h0)
				wdat_q <= wd_q[15:0];
		end
	end

	// AXI read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0;
			s_rresp <= 2'b00;
			s_arready <= 1'b1;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_arready <= 1'b0;
			case (s_araddr)
				REG_CTRL: s_rdata <= {29'h0, op_q};
				REG_STAT: s_rdata <= {28'h0, as_en_q, lowv_s, done_q,
					state_q != ST_IDLE};
				REG_ADDR: s_rdata <= {16'h0, addr_q};
				REG_DATA: s_rdata <= {16'h0, rdat_q};
				default: s_rdata <= 32'h0;
			endcase
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
			s_arready <= 1'b1;
		end
	end

	// Pin sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			op_q <= OP_READ;
			step_q <= 3'h0;
			cnt_q <= 4'h0;
			chip_sel_n <= 1'b1;
			write_n <= 1'b1;
			output_en_n <= 1'b1;
			upper_byte_lane_n <= 1'b1;
			lower_byte_lane_n <= 1'b1;
			mem_addr <= '0;
			dq_out <= 16'h0;
			dq_oe_n <= 1'b1;
			rdat_q <= 16'h0;
			done_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					// no write or save while voltage low
					if (go && !busy_s && !(lowv_s &&
						(wd_q[2:0] == OP_WRITE || wd_q[2:0] == OP_SAVE))) begin
						op_q <= wd_q[2:0];
						step_q <= 3'h0;
						cnt_q <= 4'h0;
						done_q <= 1'b0;
						state_q <= ST_ACC;
					end
				end
				ST_ACC: begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == 4'h0) begin
						// each step framed by chip select
						chip_sel_n <= 1'b0;
						upper_byte_lane_n <= 1'b0;
						lower_byte_lane_n <= 1'b0;
						// only bits 14..2 matter to the device
						mem_addr <= is_seq ? AW'(seq_addr(step_q, op_q))
							: AW'(addr_q);
						if (op_q == OP_WRITE) begin
							// write is chip select and write low
							write_n <= 1'b0;
							dq_out <= wdat_q;
							dq_oe_n <= 1'b0;
						end else begin
							// write strobe stays high in sequences
							write_n <= 1'b1;
							output_en_n <= 1'b0;
						end
					end
					if (cnt_q == SAMPLE_CYC && op_q == OP_READ)
						rdat_q <= dq_s;
					if (cnt_q == ACC_CYC) begin
						chip_sel_n <= 1'b1;
						write_n <= 1'b1;
						output_en_n <= 1'b1;
						upper_byte_lane_n <= 1'b1;
						lower_byte_lane_n <= 1'b1;
						dq_oe_n <= 1'b1;
						cnt_q <= 4'h0;
						state_q <= ST_GAP;
					end
				end
				ST_GAP: begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == GAP_CYC) begin
						cnt_q <= 4'h0;
						if (last_step) begin
							// save or restore then waits busy
							state_q <= save_like ? ST_WAIT : ST_IDLE;
							done_q <= !save_like;
						end else begin
							// steps run back to back, no other access
							step_q <= step_q + 3'h1;
							state_q <= ST_ACC;
						end
					end
				end
				ST_WAIT: begin
					cnt_q <= (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;
					if (cnt_q >= 4'h4 && !busy_s) begin
						done_q <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// shipped value; boot code rewrites it
			as_en_q <= 1'b1;
		end else if (state_q == ST_GAP && cnt_q == GAP_CYC
			&& step_q == 3'h5) begin
			if (op_q == OP_AS_DIS)
				as_en_q <= 1'b0;
			if (op_q == OP_AS_EN)
				as_en_q <= 1'b1;
		end
	end

	property p_seq_wr_high;
		@(posedge aclk) disable iff (!aresetn)
		(is_seq && !chip_sel_n) |-> write_n;
	endproperty
	a_seq_wr_high: assert property (p_seq_wr_high)
		else $error("write strobe low during sequence");

	property p_first_addr;
		@(posedge aclk) disable iff (!aresetn)
		(state_q == ST_ACC && cnt_q == 4'h1 && is_seq && step_q == 3'h0)
		|-> mem_addr[15:0] == SEQ_A1;
	endproperty
	a_first_addr: assert property (p_first_addr)
		else $error("sequence did not start at first address");

	property p_fifth_addr;
		@(posedge aclk) disable iff (!aresetn)
		(state_q == ST_ACC && cnt_q == 4'h1 && is_seq && step_q == 3'h4)
		|-> mem_addr[15:0] == SEQ_A5;
	endproperty
	a_fifth_addr: assert property (p_fifth_addr)
		else $error("fifth address wrong");

	property p_lowv_nowrite;
		@(posedge aclk) disable iff (!aresetn)
		(state_q == ST_IDLE && go && lowv_s && wd_q[2:0] == OP_WRITE)
		|=> state_q == ST_IDLE;
	endproperty
	a_lowv_nowrite: assert property (p_lowv_nowrite)
		else $error("write started while voltage low");

	property p_wr_strobe;
		@(posedge aclk) disable iff (!aresetn)
		!write_n |-> !chip_sel_n && op_q == OP_WRITE && !dq_oe_n;
	endproperty
	a_wr_strobe: assert property (p_wr_strobe)
		else $error("write strobe without write cycle");

	property p_dis_mirror;
		@(posedge aclk) disable iff (!aresetn)
		(state_q == ST_GAP && cnt_q == GAP_CYC && step_q == 3'h5
			&& op_q == OP_AS_DIS) |=> !as_en_q;
	endproperty
	a_dis_mirror: assert property (p_dis_mirror)
		else $error("autosave mirror not cleared");

	property p_en_mirror;
		@(posedge aclk) disable iff (!aresetn)
		(state_q == ST_GAP && cnt_q == GAP_CYC && step_q == 3'h5
			&& op_q == OP_AS_EN) |=> as_en_q;
	endproperty
	a_en_mirror: assert property (p_en_mirror)
		else $error("autosave mirror not set");

	sequence s_wait_busy;
		state_q == ST_WAIT && busy_s;
	endsequence
	property p_hold_busy;
		@(posedge aclk) disable iff (!aresetn)
		s_wait_busy |=> state_q == ST_WAIT && chip_sel_n;
	endproperty
	a_hold_busy: assert property (p_hold_busy)
		else $error("left wait while device busy");
endmodule

// ### src/nvsc_pkg.sv
// Purpose: shared constants for the nonvolatile SRAM host controller
// Assumes: 125 MHz aclk, AXI4-Lite register access
// Notes: command addresses are 16-bit; the device compares bits 14..2 only
package nvsc_pkg;
	localparam int CLK_MHZ = 125;
	// Register byte offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_ADDR = 4'h8;
	localparam logic [3:0] REG_DATA = 4'hC;
	// CTRL fields: op code in [2:0], write of op 0..5 is a go strobe
	localparam int CTRL_OP_LSB = 0;
	localparam logic [2:0] OP_READ = 3'h0;
	localparam logic [2:0] OP_WRITE = 3'h1;
	localparam logic [2:0] OP_AS_DIS = 3'h2;
	localparam logic [2:0] OP_AS_EN = 3'h3;
	localparam logic [2:0] OP_SAVE = 3'h4;
	localparam logic [2:0] OP_RESTORE = 3'h5;
	// STAT fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_LOWV = 2;
	localparam int STAT_AS_EN = 3;
	// Command sequence addresses
	localparam logic [15:0] SEQ_A1 = 16'h4E38;
	localparam logic [15:0] SEQ_A2 = 16'hB1C7;
	localparam logic [15:0] SEQ_A3 = 16'h83E0;
	localparam logic [15:0] SEQ_A4 = 16'h7C1F;
	localparam logic [15:0] SEQ_A5 = 16'h703F;
	localparam logic [15:0] SEQ_AS_DIS = 16'h8B45;
	localparam logic [15:0] SEQ_AS_EN = 16'h4B46;
	localparam logic [15:0] SEQ_SAVE = 16'h8FC0;
	localparam logic [15:0] SEQ_RESTORE = 16'h4C63;
	// Access timing: chip select low time and gap, in ns
	localparam int T_ACCESS_NS = 48;
	localparam int T_GAP_NS = 16;
	localparam logic [3:0] ACC_CYC = 4'((T_ACCESS_NS + 7) / 8);
	localparam logic [3:0] GAP_CYC = 4'((T_GAP_NS + 7) / 8);
	localparam logic [3:0] SAMPLE_CYC = 4'(ACC_CYC - 4'h1);
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	typedef enum {ST_IDLE, ST_ACC, ST_GAP, ST_WAIT} nvsc_state_t;
endpackage

// ### src/nvsc_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: one aclk domain
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module nvsc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

// ### tb/nvsc_mem_model.sv
// Purpose: behavioural memory device on the host pins
// Assumes: 256 words modelled, low address byte indexes
// Notes: released data lines show the inverse of last data
`timescale 1ns/10ps
module nvsc_mem_model
	import nvsc_pkg::*;
#(
	parameter int BUSY_NS = 200
) (
	// Strobes
	input wire logic chip_sel_n,
	input wire logic write_n,
	input wire logic output_en_n,
	// Address and data
	input wire logic [19:0] mem_addr,
	input wire logic [15:0] dq_out,
	output logic [15:0] dq_in,
	// Status
	input wire logic low_voltage_threshold,
	output logic save_busy_n
);
	logic [15:0] mem [256];
	logic [15:0] nv [256];
	logic [15:0] sa [5] = '{SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_A5};
	logic [15:0] last_q = 16'h0000;
	logic [2:0] seq_q = 3'h0;
	logic as_en_q, as_nv_q, drv;
	logic wr_q = 1'b0;
	logic [12:0] k;
	assign k = mem_addr[14:2];
	assign drv = !chip_sel_n && write_n && !output_en_n && save_busy_n
		&& !(seq_q == 3'h5 && (k == SEQ_SAVE[14:2]
		|| k == SEQ_RESTORE[14:2]));
	assign dq_in = drv ? mem[mem_addr[7:0]] : ~last_q;
	always @(*) if (drv) last_q = mem[mem_addr[7:0]];
	initial begin
		foreach (nv[i]) nv[i] = 16'h0000;
		mem = nv;
		as_en_q = 1'b1;
		as_nv_q = 1'b1;
		save_busy_n = 1'b1;
	end
	always @(chip_sel_n or write_n) if (!chip_sel_n && !write_n) wr_q = 1'b1;
	always @(posedge chip_sel_n) begin
		if (wr_q) begin
			if (!low_voltage_threshold && save_busy_n)
				mem[mem_addr[7:0]] = dq_out;
			seq_q = 3'h0;
		end else if (seq_q < 3'h5) begin
			seq_q = (k == sa[seq_q][14:2]) ? seq_q + 3'h1 : 3'h0;
		end else begin
			seq_q = 3'h0;
			case (k)
				SEQ_AS_DIS[14:2]: as_en_q = 1'b0;
				SEQ_AS_EN[14:2]: as_en_q = 1'b1;
				SEQ_SAVE[14:2]: if (!low_voltage_threshold) begin
					save_busy_n = 1'b0;
					#BUSY_NS;
					nv = mem;
					as_nv_q = as_en_q;
					save_busy_n = 1'b1;
				end
				SEQ_RESTORE[14:2]: begin
					save_busy_n = 1'b0;
					#BUSY_NS;
					mem = nv;
					save_busy_n = 1'b1;
				end
				default: ;
			endcase
		end
		wr_q = 1'b0;
	end
endmodule

// ### tb/nvsc_host_tb.sv
// Purpose: self-checking bench for the host controller
// Assumes: device model on the memory pins
// Notes: random word traffic plus command sequences
`timescale 1ns/10ps
module nvsc_host_tb import nvsc_pkg::*;;
	logic aclk, aresetn, awv, wv, bre, arv, rre, lowv;
	logic awr, wr, bv, arr, rv, cs_n, we_n, oe_n, busy_n;
	logic oen, ubl, lbl;
	logic [3:0] awa, ara;
	logic [31:0] wd, rd, r;
	logic [1:0] br, rr;
	logic [19:0] ma;
	logic [15:0] dqi, dqo, a, d;
	logic [15:0] ex [256];
	logic [2:0] aso [3] = '{OP_AS_DIS, OP_AS_EN, OP_AS_DIS};
	int fails, compares;
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	nvsc_host dut_u (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awa),
		.s_awvalid(awv), .s_awready(awr), .s_wdata(wd), .s_wstrb(4'hF),
		.s_wvalid(wv), .s_wready(wr), .s_bresp(br), .s_bvalid(bv),
		.s_bready(bre), .s_araddr(ara), .s_arvalid(arv), .s_arready(arr),
		.s_rdata(rd), .s_rresp(rr), .s_rvalid(rv), .s_rready(rre),
		.chip_sel_n(cs_n), .write_n(we_n), .output_en_n(oe_n),
		.upper_byte_lane_n(ubl), .lower_byte_lane_n(lbl), .mem_addr(ma),
		.dq_in(dqi), .dq_out(dqo), .dq_oe_n(oen), .save_busy_n(busy_n),
		.low_voltage_threshold(lowv));
	nvsc_mem_model #(.BUSY_NS(200)) mem_u (.chip_sel_n(cs_n),
		.write_n(we_n), .output_en_n(oe_n), .mem_addr(ma), .dq_out(dqo),
		.dq_in(dqi), .low_voltage_threshold(lowv), .save_busy_n(busy_n));
	task automatic give_verdict;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// Pin checks while a cycle is framed
	always @(posedge aclk) begin
		if (aresetn && !cs_n)
			chk("lanes", 32'h0, {30'h0, ubl, lbl});
		if (aresetn && !we_n)
			chk("wr_pins", 32'h1, {30'h0, oen, oe_n});
	end
	// Bounded wait for one edge
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 500) begin
			fails++;
			give_verdict();
		end
	endtask
	task automatic axw(input logic [3:0] ad, input logic [31:0] dt);
		int n;
		logic pa, pw, pb;
		n = 0;
		pa = 1'b1;
		pw = 1'b1;
		pb = 1'b1;
		awa <= ad;
		awv <= 1'b1;
		wd <= dt;
		wv <= 1'b1;
		while (pb) begin
			tick(n);
			if (pa && awr) begin
				pa = 1'b0;
				awv <= 1'b0;
			end
			if (pw && wr) begin
				pw = 1'b0;
				wv <= 1'b0;
			end
			if (bv) begin
				pb = 1'b0;
				chk("bresp", 32'h0, {30'h0, br});
			end
		end
	endtask
	task automatic axr(input logic [3:0] ad, output logic [31:0] dt);
		int n;
		logic pa, pr;
		n = 0;
		pa = 1'b1;
		pr = 1'b1;
		ara <= ad;
		arv <= 1'b1;
		while (pr) begin
			tick(n);
			if (pa && arr) begin
				pa = 1'b0;
				arv <= 1'b0;
			end else if (rv) begin
				pr = 1'b0;
				dt = rd;
				chk("rresp", 32'h0, {30'h0, rr});
			end
		end
	endtask
	// Start an operation, then poll until not busy
	task automatic op(input logic [2:0] o, input logic [15:0] ad,
		input logic [15:0] dt);
		logic [31:0] s;
		int n;
		n = 0;
		s = 32'h1;
		axw(REG_ADDR, {16'h0000, ad});
		axw(REG_DATA, {16'h0000, dt});
		axw(REG_CTRL, {29'h0, o});
		while (s[STAT_BUSY]) begin
			tick(n);
			axr(REG_STAT, s);
		end
		chk("done", 32'h1, 32'(s[STAT_DONE]));
	endtask
	task automatic rd_chk(input logic [15:0] ad);
		op(OP_READ, ad, 16'h0000);
		axr(REG_DATA, r);
		chk("data", {16'h0000, ex[ad[7:0]]}, r);
	endtask
	function automatic logic [31:0] exp_as(input logic [2:0] o);
		return 32'(o == OP_AS_EN);
	endfunction
	initial begin
		aresetn = 1'b0;
		{awv, wv, bre, arv, rre, lowv} = 6'h0A;
		{awa, ara, wd} = 40'h0;
		fails = 0;
		compares = 0;
		foreach (ex[i]) ex[i] = 16'h0000;
		void'($urandom(32'hF6301716));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(REG_STAT, r);
		chk("as_mirror", 32'h1, 32'(r[STAT_AS_EN]));
		for (int i = 0; i < 7; i++) begin
			a = (i == 0) ? 16'h00FF : 16'($urandom_range(0, 255));
			d = 16'($urandom);
			ex[a[7:0]] = d;
			op(OP_WRITE, a, d);
			rd_chk(a);
		end
		foreach (aso[i]) begin
			op(aso[i], 16'h0000, 16'h0000);
			axr(REG_STAT, r);
			chk("as_mirror", exp_as(aso[i]), 32'(r[STAT_AS_EN]));
			chk("as_dev", exp_as(aso[i]), 32'(mem_u.as_en_q));
		end
		axr(REG_CTRL, r);
		chk("ctrl", 32'(OP_AS_DIS), {29'h0, r[2:0]});
		a = 16'h0042;
		ex[8'h42] = 16'hA5C3;
		op(OP_WRITE, a, 16'hA5C3);
		op(OP_SAVE, 16'h0000, 16'h0000);
		chk("nv", 32'hA5C3, {16'h0000, mem_u.nv[8'h42]});
		chk("as_nv", 32'h0, 32'(mem_u.as_nv_q));
		op(OP_WRITE, a, 16'h1234);
		op(OP_RESTORE, 16'h0000, 16'h0000);
		rd_chk(a);
		lowv <= 1'b1;
		repeat (4) @(posedge aclk);
		axr(REG_STAT, r);
		chk("lowv", 32'h1, 32'(r[STAT_LOWV]));
		op(OP_AS_EN, 16'h0000, 16'h0000);
		op(OP_WRITE, a, 16'h5A5A);
		op(OP_SAVE, 16'h0000, 16'h0000);
		chk("as_nv", 32'h0, 32'(mem_u.as_nv_q));
		lowv <= 1'b0;
		repeat (4) @(posedge aclk);
		rd_chk(a);
		give_verdict();
	end
endmodule
